/* pulse_chop_regs.svh */
`ifndef PULSE_CHOP_REGS_SVH
`define PULSE_CHOP_REGS_SVH

// Register indices; the byte address on the bus is four times the index.
`define SLOT_STRIDE_IDX    10'h020
`define CFG_A_IDX          10'h108
`define CHOP_A_IDX         10'h10D
`define TRIM_A_IDX         10'h10E
`define CTRL_IDX           10'h0F0
`define STAT_IDX           10'h0F1
`define RESULT_IDX         10'h0F2

// Configuration register fields.
`define CFG_MOD_LSB        0
`define CFG_MOD_MSB        1
`define CFG_BIAS_BIT       2
`define CFG_COUNT_LSB      8
`define CFG_COUNT_MSB      15
`define CFG_RESET          16'h0200

// Chop pattern register fields.
`define CHOP_SUB_LSB       0
`define CHOP_SUB_MSB       3
`define CHOP_FLIP_LSB      4
`define CHOP_FLIP_MSB      7
`define CHOP_RESET         16'h0000
`define TRIM_RESET         16'h0000

// Control register fields.
`define CTRL_START_BIT     0
`define CTRL_SLOT_LSB      1
`define CTRL_SLOT_MSB      2

`define MIDSCALE_CODES     32'h0000_0800
`define GROUP_SIZE         4

// Phase times in ns and the cycle counts derived from them.
`define CLK_PERIOD_NS      4
`define PRECON_TIME_NS     4000
`define FLOAT_TIME_NS      2000
`define INTEG_PHASE_NS     1000
`define PRECON_CYCLES      ((`PRECON_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLOAT_CYCLES       ((`FLOAT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INTEG_CYCLES       ((`INTEG_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* pulse_chop_pkg.sv */
package pulse_chop_pkg;

  typedef enum logic [1:0] {
    MOD_CONTINUOUS,
    MOD_FLOAT,
    MOD_NONFLOAT,
    MOD_SPARE
  } conn_mod_t;

  typedef enum {
    SEQ_IDLE,
    SEQ_PRECON,
    SEQ_GAP,
    SEQ_PHASE1,
    SEQ_PHASE2,
    SEQ_CONVERT,
    SEQ_WAIT
  } seq_state_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic tiaConnect;
    logic inputTiePrecon;
    logic bpfBypass;
    logic integPos;
    logic integNeg;
    logic convStart;
  } afe_ctrl_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } adc_sample_t;

endpackage

/* pulse_chop_float_sequencer.sv */
`timescale 1ns/1ps
`include "pulse_chop_regs.svh"
module pulse_chop_float_sequencer #(
  parameter int NUM_SLOTS = 3
) (
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire pulse_chop_pkg::apb_req_t    apbReq,
  output      pulse_chop_pkg::apb_rsp_t    apbRsp,
  input  wire pulse_chop_pkg::adc_sample_t adcIn,
  output      pulse_chop_pkg::afe_ctrl_t   afeCtrl,
  output      logic                        busy,
  output      logic                        sampleDone
);
  import pulse_chop_pkg::*;

  localparam int CW = 12;

  typedef struct packed {
    logic [NUM_SLOTS-1:0][15:0] cfgReg;
    logic [NUM_SLOTS-1:0][15:0] chopReg;
    logic [NUM_SLOTS-1:0][15:0] trimReg;
    apb_rsp_t                   rsp;
    seq_state_t                 state;
    logic [1:0]                 slot;
    logic [CW-1:0]              timer;
    logic [7:0]                 pulseIdx;
    logic [7:0]                 pulseTotal;
    logic signed [31:0]         acc;
    logic [31:0]                result;
    logic                       busy;
    logic                       done;
    afe_ctrl_t                  afe;
  } state_t;

  state_t cur_reg;
  state_t cur_next;

  logic [9:0]  regIdx;
  logic [31:0] readData;
  logic        hit;
  logic [15:0] slotCfg;
  logic [15:0] slotChop;
  conn_mod_t   modSel;
  logic [1:0]  pos;
  logic        flipNow;
  logic        subNow;
  logic [7:0]  reqCount;

  assign regIdx   = apbReq.paddr[11:2];
  assign slotCfg  = cur_reg.cfgReg[cur_reg.slot];
  assign slotChop = cur_reg.chopReg[cur_reg.slot];
  assign modSel   = conn_mod_t'(slotCfg[`CFG_MOD_MSB:`CFG_MOD_LSB]);
  // Only the low two bits of the pulse index pick the pattern bit, so the
  // four-bit pattern is reused for every group of four pulses.
  assign pos      = cur_reg.pulseIdx[1:0];
  assign flipNow  = slotChop[`CHOP_FLIP_LSB + pos];
  assign subNow   = slotChop[`CHOP_SUB_LSB + pos];

  // Read multiplexer and address decode.
  always_comb begin
    readData = 32'h0000_0000;
    hit      = 1'b0;
    for (int s = 0; s < NUM_SLOTS; s++) begin
      if (regIdx == 10'(`CFG_A_IDX + s * `SLOT_STRIDE_IDX)) begin
        readData = {16'h0000, cur_reg.cfgReg[s]};
        hit      = 1'b1;
      end
      if (regIdx == 10'(`CHOP_A_IDX + s * `SLOT_STRIDE_IDX)) begin
        readData = {16'h0000, cur_reg.chopReg[s]};
        hit      = 1'b1;
      end
      if (regIdx == 10'(`TRIM_A_IDX + s * `SLOT_STRIDE_IDX)) begin
        readData = {16'h0000, cur_reg.trimReg[s]};
        hit      = 1'b1;
      end
    end
    if (regIdx == `CTRL_IDX) begin
      readData = {29'h0000_0000, cur_reg.slot, 1'b0};
      hit      = 1'b1;
    end
    if (regIdx == `STAT_IDX) begin
      readData = {16'h0000, cur_reg.pulseIdx, 6'h00, cur_reg.done, cur_reg.busy};
      hit      = 1'b1;
    end
    if (regIdx == `RESULT_IDX) begin
      readData = cur_reg.result;
      hit      = 1'b1;
    end
  end

  // Pulse count requested for the chosen slot. With a flip pattern in use the
  // block is chopping, so an odd count is made even, up by one or 255 down to 254, to keep polarities paired.
  always_comb begin
    reqCount = cur_reg.cfgReg[apbReq.pwdata[`CTRL_SLOT_MSB:`CTRL_SLOT_LSB]]
               [`CFG_COUNT_MSB:`CFG_COUNT_LSB];
    if (reqCount == 8'h00) begin
      reqCount = 8'h01;
    end
    if (cur_reg.chopReg[apbReq.pwdata[`CTRL_SLOT_MSB:`CTRL_SLOT_LSB]]
        [`CHOP_FLIP_MSB:`CHOP_FLIP_LSB] != 4'h0 && reqCount[0]) begin
      reqCount = (reqCount == 8'hFF) ? 8'hFE : 8'(reqCount + 8'h01);
    end
  end

  always_comb begin
    cur_next = cur_reg;

    // APB slave: answer one cycle after the setup phase.
    cur_next.rsp.pready = 1'b0;
    if (apbReq.psel && !apbReq.penable) begin
      cur_next.rsp.pready  = 1'b1;
      cur_next.rsp.pslverr = !hit;
      cur_next.rsp.prdata  = apbReq.pwrite ? 32'h0000_0000 : readData;
    end
    if (apbReq.psel && apbReq.penable && cur_reg.rsp.pready && apbReq.pwrite) begin
      for (int s = 0; s < NUM_SLOTS; s++) begin
        if (regIdx == 10'(`CFG_A_IDX + s * `SLOT_STRIDE_IDX)) begin
          cur_next.cfgReg[s] = apbReq.pwdata[15:0];
        end
        if (regIdx == 10'(`CHOP_A_IDX + s * `SLOT_STRIDE_IDX)) begin
          cur_next.chopReg[s] = apbReq.pwdata[15:0];
        end
        // The offset trims are stored as written; in chop mode software
        // keeps them at zero since the add/subtract already cancels offsets.
        if (regIdx == 10'(`TRIM_A_IDX + s * `SLOT_STRIDE_IDX)) begin
          cur_next.trimReg[s] = apbReq.pwdata[15:0];
        end
      end
      if (regIdx == `CTRL_IDX && apbReq.pwdata[`CTRL_START_BIT] && !cur_reg.busy &&
          32'(apbReq.pwdata[`CTRL_SLOT_MSB:`CTRL_SLOT_LSB]) < NUM_SLOTS) begin
        cur_next.slot       = apbReq.pwdata[`CTRL_SLOT_MSB:`CTRL_SLOT_LSB];
        cur_next.state      = SEQ_PRECON;
        cur_next.timer      = CW'(`PRECON_CYCLES - 1);
        cur_next.pulseIdx   = 8'h00;
        cur_next.pulseTotal = reqCount;
        cur_next.acc        = 32'sh0000_0000;
        cur_next.busy       = 1'b1;
        cur_next.done       = 1'b0;
      end
    end

    // Pulse sequencer.
    case (cur_reg.state)
      SEQ_IDLE: begin
      end
      SEQ_PRECON: begin
        if (cur_reg.timer == '0) begin
          cur_next.state = SEQ_GAP;
          cur_next.timer = CW'(`FLOAT_CYCLES - 1);
        end else begin
          cur_next.timer = cur_reg.timer - 1'b1;
        end
      end
      SEQ_GAP: begin
        if (cur_reg.timer == '0) begin
          cur_next.state = SEQ_PHASE1;
          cur_next.timer = CW'(`INTEG_CYCLES - 1);
        end else begin
          cur_next.timer = cur_reg.timer - 1'b1;
        end
      end
      SEQ_PHASE1: begin
        if (cur_reg.timer == '0) begin
          cur_next.state = SEQ_PHASE2;
          cur_next.timer = CW'(`INTEG_CYCLES - 1);
        end else begin
          cur_next.timer = cur_reg.timer - 1'b1;
        end
      end
      SEQ_PHASE2: begin
        if (cur_reg.timer == '0) begin
          cur_next.state = SEQ_CONVERT;
        end else begin
          cur_next.timer = cur_reg.timer - 1'b1;
        end
      end
      SEQ_CONVERT: begin
        cur_next.state = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (adcIn.valid) begin
          // Inverted sequences carry a set subtract bit and are taken away.
          if (subNow) begin
            cur_next.acc = cur_reg.acc - 32'(signed'(adcIn.data));
          end else begin
            cur_next.acc = cur_reg.acc + 32'(signed'(adcIn.data));
          end
          cur_next.pulseIdx = cur_reg.pulseIdx + 8'h01;
          if (cur_reg.pulseIdx + 8'h01 == cur_reg.pulseTotal) begin
            cur_next.state  = SEQ_IDLE;
            cur_next.busy   = 1'b0;
            cur_next.done   = 1'b1;
            cur_next.result = 32'(cur_next.acc) +
                              (slotCfg[`CFG_BIAS_BIT] ? `MIDSCALE_CODES : 32'h0000_0000);
          end else begin
            cur_next.state = SEQ_GAP;
            cur_next.timer = CW'(`FLOAT_CYCLES - 1);
          end
        end
      end
      default: begin
        cur_next.state = SEQ_IDLE;
        cur_next.busy  = 1'b0;
      end
    endcase

    // Analog switch controls, decoded from the next state so they leave flops.
    cur_next.afe = '0;
    cur_next.afe.convStart = (cur_next.state == SEQ_CONVERT);
    if (cur_next.state != SEQ_IDLE) begin
      // Filter is bypassed in float mode; its output cannot be aligned there.
      cur_next.afe.bpfBypass = (modSel == MOD_FLOAT);
      if (cur_next.state == SEQ_PHASE1) begin
        cur_next.afe.integPos = !flipNow;
        cur_next.afe.integNeg = flipNow;
      end
      if (cur_next.state == SEQ_PHASE2) begin
        cur_next.afe.integPos = flipNow;
        cur_next.afe.integNeg = !flipNow;
      end
      case (modSel)
        MOD_CONTINUOUS: begin
          cur_next.afe.tiaConnect     = (cur_next.state != SEQ_PRECON);
          cur_next.afe.inputTiePrecon = (cur_next.state == SEQ_PRECON);
        end
        MOD_FLOAT: begin
          // Precondition, float through the gap and positive phase, and
          // connect only for the negative phase (phase 1 when the flip bit is set) so all charge lands there.
          cur_next.afe.inputTiePrecon = (cur_next.state == SEQ_PRECON);
          cur_next.afe.tiaConnect     = cur_next.afe.integNeg;
        end
        MOD_NONFLOAT: begin
          cur_next.afe.tiaConnect     = cur_next.afe.integNeg;
          cur_next.afe.inputTiePrecon = !cur_next.afe.integNeg;
        end
        default: begin
          cur_next.afe.inputTiePrecon = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cur_reg            <= '0;
      cur_reg.cfgReg     <= {NUM_SLOTS{`CFG_RESET}};
      cur_reg.chopReg    <= {NUM_SLOTS{`CHOP_RESET}};
      cur_reg.trimReg    <= {NUM_SLOTS{`TRIM_RESET}};
      cur_reg.state      <= SEQ_IDLE;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign apbRsp     = cur_reg.rsp;
  assign afeCtrl    = cur_reg.afe;
  assign busy       = cur_reg.busy;
  assign sampleDone = cur_reg.done;

endmodule

/* pulse_chop_assertions.sv */
`timescale 1ns/1ps
module pulse_chop_assertions
  import pulse_chop_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        rstn,
  input wire pulse_chop_pkg::apb_req_t    apbReq,
  input wire pulse_chop_pkg::apb_rsp_t    apbRsp,
  input wire pulse_chop_pkg::adc_sample_t adcIn,
  input wire pulse_chop_pkg::afe_ctrl_t   afeCtrl,
  input wire logic                        busy,
  input wire logic                        sampleDone
);
  import pulse_chop_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence floatOpen;
    !afeCtrl.tiaConnect && !afeCtrl.integPos && !afeCtrl.integNeg;
  endsequence
  sequence pulseClose;
    afeCtrl.integNeg ^ afeCtrl.convStart;
  endsequence
  float_gap_a: assert property ($fell(afeCtrl.inputTiePrecon) && afeCtrl.bpfBypass
    |-> floatOpen [*8]) else $error("float gap not open");
  float_neg_a: assert property (afeCtrl.bpfBypass && afeCtrl.tiaConnect
    |-> afeCtrl.integNeg) else $error("float connect outside negative phase");
  bypass_busy_a: assert property (afeCtrl.bpfBypass |-> busy)
    else $error("bypass outside sequence");
  tie_excl_a: assert property (!(afeCtrl.tiaConnect && afeCtrl.inputTiePrecon))
    else $error("input tied and connected");
  conn_hold_a: assert property (afeCtrl.tiaConnect && !afeCtrl.bpfBypass
    |=> afeCtrl.tiaConnect || afeCtrl.inputTiePrecon || !busy) else $error("input left open");
  pos_swap_a: assert property ($fell(afeCtrl.integPos) |-> pulseClose)
    else $error("phase order broken");
  neg_swap_a: assert property ($fell(afeCtrl.integNeg)
    |-> afeCtrl.integPos ^ afeCtrl.convStart) else $error("phase order broken");
  phase_len_a: assert property ($rose(afeCtrl.integPos) |-> afeCtrl.integPos [*8])
    else $error("phase too short");
  conv_pulse_a: assert property (afeCtrl.convStart |=> !afeCtrl.convStart && busy)
    else $error("conversion pulse wrong");
  apb_wait_a: assert property (apbReq.psel && !apbReq.penable
    |=> apbRsp.pready ##1 !apbRsp.pready) else $error("ready timing wrong");
  done_end_a: assert property ($rose(sampleDone) |-> $fell(busy))
    else $error("done without end of busy");
endmodule

/* adc_sensor_model.sv */
`timescale 1ns/1ps
module adc_sensor_model
  import pulse_chop_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rstn,
  input  wire logic                        convStart,
  input  wire logic [3:0]                  lat,
  output      pulse_chop_pkg::adc_sample_t adcOut
);
  import pulse_chop_pkg::*;
  logic [15:0] k;
  logic [3:0]  cnt;
  logic        pend;
  // Data toggles outside the valid cycle so a late sample is never read by luck.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      k <= '0;
      cnt <= '0;
      pend <= 1'b0;
      adcOut <= '0;
    end else begin
      adcOut.valid <= 1'b0;
      adcOut.data <= ~adcOut.data;
      if (convStart) begin
        pend <= 1'b1;
        cnt <= lat;
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        adcOut.valid <= 1'b1;
        adcOut.data <= 16'h0040 * k - 16'h0070;
        k <= k + 16'h0001;
      end
    end
  end
endmodule

/* pulse_chop_float_sequencer_test.sv */
`timescale 1ns/1ps
module pulse_chop_float_sequencer_test;
  import pulse_chop_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  apb_req_t    apbReq = '0;
  apb_rsp_t    apbRsp;
  adc_sample_t adcIn;
  afe_ctrl_t   afeCtrl;
  logic        busy;
  logic        sampleDone;
  logic [3:0]  lat = 4'h0;
  logic [31:0] rd;
  logic        err;
  int          failCount = 0;
  int          nChecks = 0;
  int          k = 0;
  pulse_chop_float_sequencer DUT (.clk_sys(clk_sys), .rstn(rstn), .apbReq(apbReq),
    .apbRsp(apbRsp), .adcIn(adcIn), .afeCtrl(afeCtrl), .busy(busy), .sampleDone(sampleDone));
  adc_sensor_model sensor (.clk_sys(clk_sys), .rstn(rstn), .convStart(afeCtrl.convStart),
    .lat(lat), .adcOut(adcIn));
  initial forever #2 clk_sys = ~clk_sys;
  task automatic closeOut();
    if (failCount == 0 && nChecks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      failCount++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  // The request stands until ready is seen high at a rising edge; data is taken there.
  task automatic xfer(input logic w, input logic [9:0] idx, input logic [31:0] d);
    @(posedge clk_sys);
    apbReq <= '{1'b1, 1'b0, w, {idx, 2'b00}, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    do @(posedge clk_sys); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic runSample(input int s, input logic [15:0] cfg, input logic [7:0] chop,
                           input int n);
    int          acc;
    logic [15:0] v;
    acc = cfg[2] ? 2048 : 0;
    xfer(1'b1, 10'h108 + 10'(32 * s), {16'h0000, cfg});
    xfer(1'b1, 10'h10D + 10'(32 * s), {24'h000000, chop});
    xfer(1'b1, 10'h0F0, 32'(1 + 2 * s));
    @(negedge clk_sys);
    check("busy", 32'h1, {31'h0, busy});
    for (int i = 0; i < n; i++) begin
      v = 16'h0040 * 16'(k) - 16'h0070;
      acc += chop[i % 4] ? -int'($signed(v)) : int'($signed(v));
      k++;
    end
    for (int i = 0; i < 30000 && sampleDone !== 1'b1; i++) @(negedge clk_sys);
    check("done", 32'h1, {31'h0, sampleDone});
    xfer(1'b0, 10'h0F2, 32'h0);
    check("result", 32'(acc), rd);
    xfer(1'b0, 10'h0F1, 32'h0);
    check("status", {16'h0, 8'(n), 8'h02}, {16'h0, rd[15:0]});
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    xfer(1'b0, 10'h108, 32'h0);
    check("cfg", 32'h0000_0200, rd);
    xfer(1'b0, 10'h14D, 32'h0);
    check("chopC", 32'h0, rd);
    xfer(1'b1, 10'h12D, 32'h0000_005A);
    xfer(1'b0, 10'h12D, 32'h0);
    check("chopB", 32'h0000_005A, rd);
    xfer(1'b0, 10'h3FF, 32'h0);
    check("slverr", 32'h1, {31'h0, err});
    xfer(1'b1, 10'h10E, 32'h0);
    runSample(0, 16'h0200, 8'h00, 2);
    lat <= 4'h9;
    // Odd count with chop active must round up to an even number of pulses.
    runSample(1, 16'h0705, 8'hAA, 8);
    runSample(2, 16'h0502, 8'h59, 6);
    closeOut();
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    failCount++;
    closeOut();
  end
endmodule
bind pulse_chop_float_sequencer pulse_chop_assertions chk (.clk_sys(clk_sys), .rstn(rstn),
  .apbReq(apbReq), .apbRsp(apbRsp), .adcIn(adcIn), .afeCtrl(afeCtrl), .busy(busy),
  .sampleDone(sampleDone));
